// ===== asb_pkg.sv
package asb_pkg;
    localparam int ADDR_W = 18;
    localparam int DATA_W = 16;
    localparam int LANE_W = 8;
    localparam int CLK_MHZ = 125;
    // Power-up wait before first access, in microseconds
    localparam int POWER_US = 100;
    localparam int POWER_CYC = POWER_US * CLK_MHZ;
    // Least times in ns, rounded up to whole 8 ns cycles
    localparam int CLK_NS = 8;
    localparam int T_RC_NS = 10;
    localparam int T_AA_NS = 10;
    localparam int T_PWE_NS = 7;
    localparam int T_HZWE_NS = 5;
    localparam int T_SD_NS = 5;
    // Two more cycles let the pad synchroniser see settled data
    localparam int RD_CYC = (T_AA_NS + CLK_NS - 1) / CLK_NS + 2;
    localparam int WR_CYC =
        ((T_HZWE_NS + T_SD_NS > T_PWE_NS ? T_HZWE_NS + T_SD_NS : T_PWE_NS)
        + CLK_NS - 1) / CLK_NS;
    localparam int CNT_W = 16;
    localparam logic [DATA_W-1:0] DATA_RST = 16'h0000;

    typedef enum logic [2:0] {
        ASB_POWER = 3'b000,
        ASB_IDLE = 3'b001,
        ASB_RD = 3'b011,
        ASB_WR = 3'b010,
        ASB_WR_END = 3'b110,
        ASB_RD_END = 3'b111
    } asb_state_t;
endpackage

// ===== asb_pins_if.sv
`timescale 1ns/100ps
interface asb_pins_if;
    logic [asb_pkg::DATA_W-1:0] dq_in;
    logic [asb_pkg::DATA_W-1:0] dq_sync;
    modport ctl (output dq_in, input dq_sync);
    modport sync (input dq_in, output dq_sync);
endinterface

// ===== asb_sync.sv
`timescale 1ns/100ps
module asb_sync #(
    parameter int WIDTH = 16
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] din,
    output logic [WIDTH-1:0] dout
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] held;
    } asb_sync_st_t;
    asb_sync_st_t st;
    asb_sync_st_t next_st;

    always_comb
    begin
        next_st.meta = din;
        next_st.held = st.meta;
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= '0;
        else
            st <= next_st;
    end

    assign dout = st.held;
endmodule // asb_sync

// ===== asb_host.sv
`timescale 1ns/100ps
// Function
// - A write needs all three low; the first to rise ends it.
// - Write data stays stable across the edge that ends the write.
// - Write strobe stays high through any read.
// - Address is valid no later than chip select falling on a read.
// - At least 100 us pass after power-up before the first access.
// - Strobe-controlled writes last bus turn-off plus data setup.
module asb_host #(
    parameter int POWER_CYCLES = asb_pkg::POWER_CYC
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [asb_pkg::ADDR_W-1:0] req_addr,
    input wire logic [1:0] req_lane,
    input wire logic [asb_pkg::DATA_W-1:0] req_wdata,
    output logic req_ready,
    output logic rd_valid,
    output logic [asb_pkg::DATA_W-1:0] rd_data,
    output logic [asb_pkg::ADDR_W-1:0] mem_addr,
    output logic chip_sel_n,
    output logic out_drive_n,
    output logic write_n,
    output logic low_byte_sel_n,
    output logic high_byte_sel_n,
    input wire logic [asb_pkg::DATA_W-1:0] dq_in,
    output logic [asb_pkg::DATA_W-1:0] dq_out,
    output logic [asb_pkg::DATA_W-1:0] dq_oe
);
    typedef struct packed {
        asb_pkg::asb_state_t state;
        logic [asb_pkg::CNT_W-1:0] cnt;
        logic ready;
        logic rvalid;
        logic [asb_pkg::DATA_W-1:0] rdata;
        logic [asb_pkg::ADDR_W-1:0] addr;
        logic cs_n;
        logic oe_n;
        logic we_n;
        logic [1:0] lane_n;
        logic [asb_pkg::DATA_W-1:0] wdata;
        logic [asb_pkg::DATA_W-1:0] oe;
    } asb_st_t;

    localparam logic [asb_pkg::CNT_W-1:0] PWR_LAST =
        asb_pkg::CNT_W'(POWER_CYCLES - 1);
    localparam logic [asb_pkg::CNT_W-1:0] RD_LAST =
        asb_pkg::CNT_W'(asb_pkg::RD_CYC - 1);
    localparam logic [asb_pkg::CNT_W-1:0] WR_LAST =
        asb_pkg::CNT_W'(asb_pkg::WR_CYC - 1);
    localparam int LANES = asb_pkg::DATA_W / asb_pkg::LANE_W;

    // Pins released and the power wait armed
    localparam asb_st_t ST_RST = '{
        state: asb_pkg::ASB_POWER,
        cnt: '0,
        ready: 1'b0,
        rvalid: 1'b0,
        rdata: '0,
        addr: '0,
        cs_n: 1'b1,
        oe_n: 1'b1,
        we_n: 1'b1,
        lane_n: 2'b11,
        wdata: asb_pkg::DATA_RST,
        oe: '0
    };

    asb_st_t st;
    asb_st_t next_st;
    asb_pins_if pins ();
    logic [asb_pkg::DATA_W-1:0] lane_mask;
    logic [asb_pkg::DATA_W-1:0] req_mask;
    logic take;

    assign pins.dq_in = dq_in;

    // Lane code 00 carries nothing and is dropped
    assign take = req_valid && req_lane != 2'b00;

    // Pad data is asynchronous to sys_clk
    asb_sync #(
        .WIDTH(asb_pkg::DATA_W)
    ) u_sync (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .din(pins.dq_in),
        .dout(pins.dq_sync)
    );

    // Byte lanes behave alike, one copy each
    for (genvar i = 0; i < LANES; i++)
    begin : g_lane
        assign lane_mask[i*asb_pkg::LANE_W +: asb_pkg::LANE_W] =
            {asb_pkg::LANE_W{~st.lane_n[i]}};
        assign req_mask[i*asb_pkg::LANE_W +: asb_pkg::LANE_W] =
            {asb_pkg::LANE_W{req_lane[i]}};
    end

    always_comb
    begin
        next_st = st;
        next_st.rvalid = 1'b0;
        case (st.state)
            asb_pkg::ASB_POWER:
            begin
                // Pins stay released until the wait runs out
                next_st.cnt = st.cnt + 1'b1;
                if (st.cnt == PWR_LAST)
                begin
                    next_st.state = asb_pkg::ASB_IDLE;
                    next_st.ready = 1'b1;
                end
            end
            asb_pkg::ASB_IDLE:
            begin
                // Standby between accesses; lines released
                if (take)
                begin
                    next_st.ready = 1'b0;
                    next_st.addr = req_addr;
                    next_st.cs_n = 1'b0;
                    next_st.lane_n = ~req_lane;
                    next_st.cnt = '0;
                    if (req_write)
                    begin
                        next_st.state = asb_pkg::ASB_WR;
                        next_st.we_n = 1'b0;
                        // Output drive off so the lines never fight
                        next_st.oe_n = 1'b1;
                        next_st.wdata = req_wdata;
                        // Only selected lanes driven
                        next_st.oe = req_mask;
                    end
                    else
                    begin
                        next_st.state = asb_pkg::ASB_RD;
                        next_st.we_n = 1'b1;
                        next_st.oe_n = 1'b0;
                        next_st.oe = '0;
                    end
                end
            end
            asb_pkg::ASB_RD:
            begin
                next_st.cnt = st.cnt + 1'b1;
                // Two cycles past access time cover the synchroniser
                if (st.cnt == RD_LAST)
                begin
                    next_st.state = asb_pkg::ASB_RD_END;
                    // Unselected lanes read back as zero
                    next_st.rdata = pins.dq_sync & lane_mask;
                    next_st.rvalid = 1'b1;
                    next_st.cs_n = 1'b1;
                    next_st.oe_n = 1'b1;
                    next_st.lane_n = 2'b11;
                end
            end
            asb_pkg::ASB_WR:
            begin
                // Pulse covers turn-off plus data setup
                next_st.cnt = st.cnt + 1'b1;
                if (st.cnt == WR_LAST)
                begin
                    // Strobe rises first and ends the write
                    next_st.state = asb_pkg::ASB_WR_END;
                    next_st.we_n = 1'b1;
                end
            end
            asb_pkg::ASB_WR_END:
            begin
                // Data held one cycle past the ending edge
                next_st.cs_n = 1'b1;
                next_st.lane_n = 2'b11;
                next_st.oe = '0;
                next_st.state = asb_pkg::ASB_RD_END;
            end
            asb_pkg::ASB_RD_END:
            begin
                // Recovery cycle keeps the cycle time above minimum
                next_st.state = asb_pkg::ASB_IDLE;
                next_st.ready = 1'b1;
            end
            default:
            begin
                // Illegal code restarts from safe values and waits again
                next_st = ST_RST;
            end
        endcase
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            st <= ST_RST;
        else
            st <= next_st;
    end

    assign req_ready = st.ready;
    assign rd_valid = st.rvalid;
    assign rd_data = st.rdata;
    assign mem_addr = st.addr;
    assign chip_sel_n = st.cs_n;
    assign out_drive_n = st.oe_n;
    assign write_n = st.we_n;
    assign low_byte_sel_n = st.lane_n[0];
    assign high_byte_sel_n = st.lane_n[1];
    assign dq_out = st.wdata;
    assign dq_oe = st.oe;
endmodule // asb_host

// ===== asb_monitor.sv
`timescale 1ns/100ps
module asb_monitor #(
    parameter int POWER_CYCLES = 20
) (
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic req_valid,
    input wire logic req_write,
    input wire logic [17:0] req_addr,
    input wire logic [1:0] req_lane,
    input wire logic req_ready,
    input wire logic rd_valid,
    input wire logic [17:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic out_drive_n,
    input wire logic write_n,
    input wire logic low_byte_sel_n,
    input wire logic high_byte_sel_n,
    input wire logic [15:0] dq_oe
);
    logic tk;
    logic [15:0] cnt;
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rst_n);
    assign tk = req_valid && req_ready && req_lane != 2'h0;
    always_ff @(posedge sys_clk or negedge rst_n)
        if (!rst_n)
            cnt <= 16'h0000;
        else if (cnt < POWER_CYCLES)
            cnt <= cnt + 16'h0001;
    property p_pwr;
        cnt < POWER_CYCLES |-> !req_ready && chip_sel_n;
    endproperty
    a_pwr: assert property (p_pwr) else $error("early access");
    property p_rd; !out_drive_n |-> write_n; endproperty
    a_rd: assert property (p_rd) else $error("strobe in read");
    property p_wst;
        $fell(write_n) |-> !chip_sel_n && !(low_byte_sel_n && high_byte_sel_n);
    endproperty
    a_wst: assert property (p_wst) else $error("bad write start");
    property p_wlen;
        $fell(write_n) |-> !chip_sel_n ##1 !write_n && !chip_sel_n;
    endproperty
    a_wlen: assert property (p_wlen) else $error("write too short");
    property p_hold; $rose(write_n) |-> !chip_sel_n && dq_oe != 0; endproperty
    a_hold: assert property (p_hold) else $error("data not held");
    property p_addr;
        tk |=> !chip_sel_n && mem_addr == $past(req_addr);
    endproperty
    a_addr: assert property (p_addr) else $error("bad address");
    property p_lane;
        tk |=> {high_byte_sel_n, low_byte_sel_n} == ~$past(req_lane);
    endproperty
    a_lane: assert property (p_lane) else $error("bad lanes");
    property p_rdv;
        tk && !req_write |-> !rd_valid [*5] ##1 rd_valid;
    endproperty
    a_rdv: assert property (p_rdv) else $error("no read data");
    property p_oe;
        (dq_oe[7:0] == 0 || !low_byte_sel_n && out_drive_n) &&
        (dq_oe[15:8] == 0 || !high_byte_sel_n && out_drive_n);
    endproperty
    a_oe: assert property (p_oe) else $error("drive on wrong lane");
endmodule // asb_monitor
bind asb_host asb_monitor #(.POWER_CYCLES(POWER_CYCLES)) i_mon (
    .sys_clk, .rst_n, .req_valid, .req_write, .req_addr, .req_lane,
    .req_ready, .rd_valid, .mem_addr, .chip_sel_n, .out_drive_n,
    .write_n, .low_byte_sel_n, .high_byte_sel_n, .dq_oe);

// ===== asb_mem_model.sv
`timescale 1ns/100ps
module asb_mem_model (
    input wire logic sys_clk,
    input wire logic [17:0] mem_addr,
    input wire logic chip_sel_n,
    input wire logic out_drive_n,
    input wire logic write_n,
    input wire logic low_byte_sel_n,
    input wire logic high_byte_sel_n,
    input wire logic [15:0] dq_out,
    output logic [15:0] dq_in
);
    logic [15:0] mem [logic [17:0]];
    logic [15:0] junk = 16'h5A5A;
    logic [15:0] wdat;
    logic [1:0] wmask;
    logic [17:0] waddr;
    logic [15:0] rd;
    logic wr_on;
    logic [15:0] dq_now;
    localparam int T_ACC = 10;
    assign wr_on = !chip_sel_n && !write_n &&
        !(low_byte_sel_n && high_byte_sel_n);
    // Floating lines keep moving so stale data never passes
    always @(posedge sys_clk)
        junk <= ~junk;
    always @(*)
        if (wr_on)
        begin
            wdat = dq_out;
            wmask = ~{high_byte_sel_n, low_byte_sel_n};
            waddr = mem_addr;
        end
    always @(negedge wr_on)
    begin
        if (wmask[0]) mem[waddr][7:0] = wdat[7:0];
        if (wmask[1]) mem[waddr][15:8] = wdat[15:8];
    end
    always @(*)
    begin
        rd = mem.exists(mem_addr) ? mem[mem_addr] : ~junk;
        dq_now = junk;
        if (!chip_sel_n && !out_drive_n && write_n)
        begin
            if (!low_byte_sel_n) dq_now[7:0] = rd[7:0];
            if (!high_byte_sel_n) dq_now[15:8] = rd[15:8];
        end
    end
    // Pads settle only after the access time
    always @(dq_now)
        dq_in <= #(T_ACC) dq_now;
endmodule // asb_mem_model

// ===== testbench.sv
`timescale 1ns/100ps
module testbench;
    localparam int PW = 20;
    logic sys_clk, rst_n, req_valid, req_write, req_ready, rd_valid;
    logic chip_sel_n, out_drive_n, write_n, low_byte_sel_n, high_byte_sel_n;
    logic [17:0] req_addr, mem_addr;
    logic [1:0] req_lane;
    logic [15:0] req_wdata, rd_data, dq_in, dq_out, dq_oe;
    int errors = 0;
    int tests_run = 0;
    int cyc = 0;
    asb_host #(.POWER_CYCLES(PW)) i_dut (.sys_clk, .rst_n, .req_valid,
        .req_write, .req_addr, .req_lane, .req_wdata, .req_ready,
        .rd_valid, .rd_data, .mem_addr, .chip_sel_n, .out_drive_n,
        .write_n, .low_byte_sel_n, .high_byte_sel_n, .dq_in, .dq_out,
        .dq_oe);
    asb_mem_model i_mem (.sys_clk, .mem_addr, .chip_sel_n, .out_drive_n,
        .write_n, .low_byte_sel_n, .high_byte_sel_n, .dq_out, .dq_in);
    initial
    begin
        sys_clk = 0;
        forever #4 sys_clk = ~sys_clk;
    end
    task automatic finish_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cyc++;
        if (cyc == 1000)
        begin
            errors++;
            finish_test();
        end
    end
    task automatic cmp(string what, logic [15:0] exp, logic [15:0] got);
        tests_run++;
        if (got !== exp)
        begin
            errors++;
            $display("BAD %s exp %h got %h", what, exp, got);
        end
    endtask
    task automatic tick();
        @(posedge sys_clk);
        #1;
    endtask
    task automatic send(logic w, logic [17:0] a, logic [1:0] l,
        logic [15:0] d);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n++ < 20) tick();
        cmp("ready", 16'h0001, {15'h0000, req_ready});
        req_valid = 1;
        req_write = w;
        req_addr = a;
        req_lane = l;
        req_wdata = d;
        tick();
        req_valid = 0;
    endtask
    task automatic rd_chk(logic [17:0] a, logic [1:0] l, logic [15:0] e);
        int n;
        n = 0;
        send(0, a, l, 16'h0000);
        while (rd_valid !== 1'b1 && n++ < 8) tick();
        cmp("rd_valid", 16'h0001, {15'h0000, rd_valid});
        cmp("rd_data", e, rd_data);
    endtask
    task automatic t_power();
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 100)
        begin
            cmp("standby", 16'h0001, {15'h0000, chip_sel_n});
            tick();
            n++;
        end
        cmp("power wait", 16'(PW), 16'(n));
    endtask
    task automatic t_lanes();
        send(1, 18'h3FFFF, 2'h3, 16'h1234);
        send(1, 18'h3FFFF, 2'h2, 16'hABCD);
        send(1, 18'h00000, 2'h3, 16'h5566);
        send(1, 18'h00000, 2'h1, 16'h9988);
        rd_chk(18'h3FFFF, 2'h3, 16'hAB34);
        rd_chk(18'h3FFFF, 2'h2, 16'hAB00);
        rd_chk(18'h3FFFF, 2'h1, 16'h0034);
        rd_chk(18'h00000, 2'h3, 16'h5588);
    endtask
    task automatic t_refuse();
        send(1, 18'h00000, 2'h0, 16'hFFFF);
        cmp("ready", 16'h0001, {15'h0000, req_ready});
        cmp("select", 16'h0001, {15'h0000, chip_sel_n});
        rd_chk(18'h00000, 2'h3, 16'h5588);
    endtask
    initial
    begin
        rst_n = 0;
        req_valid = 0;
        req_write = 0;
        req_addr = 0;
        req_lane = 0;
        req_wdata = 0;
        repeat (5) @(posedge sys_clk);
        #1;
        rst_n = 1;
        t_power();
        t_lanes();
        t_refuse();
        finish_test();
    end
endmodule // testbench
